// file: verilog/lpc_ctrl.sv
/*
  Power mode and system clock controller: sequences Run, Sleep, Stop and
  Standby, drives regulator and clock enables, selects the system clock
  and bus prescalers. Assumes wake and event inputs from pins are raw and
  the remaining inputs come from logic on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl #(
  parameter int unsigned MON_CYC = lpc_pkg::LPC_MON_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire lpc_pkg::lpc_mode_t target_mode_i,
  input wire logic low_power_regulator_sel_i,
  input wire logic wait_i,
  input wire logic irq_event_i,
  input wire logic [lpc_pkg::LPC_EVT_W-1:0] external_event_lines_i,
  input wire logic [7:0] wakeup_pins_i,
  input wire logic rtc_event_i,
  input wire logic independent_watchdog_reset_i,
  input wire logic external_reset_pin_n_i,
  input wire logic [2:0] rc_request_i,
  input wire lpc_pkg::lpc_src_t clk_src_sel_i,
  input wire logic [2:0] ahb_div_i,
  input wire logic [2:0] apb_div_i,
  input wire logic [7:0] src_mhz_i,
  input wire logic ext_clk_i,
  input wire logic css_irq_en_i,
  input wire logic clock_recovery_unit_en_i,
  input wire logic supply_voltage_monitor_en_i,
  input wire logic supply_voltage_monitor_below_i,
  output lpc_pkg::lpc_mode_t mode_o,
  output lpc_pkg::lpc_reg_ctl_t reg_ctl_o,
  output lpc_pkg::lpc_clk_ctl_t clk_ctl_o,
  output lpc_pkg::lpc_src_t clk_src_o,
  output logic pll_from_rc48_o,
  output logic [2:0] ahb_div_o,
  output logic [2:0] apb_div_o,
  output logic [2:0] rc_grant_o,
  output logic rtc_wdg_clk_en_o,
  output logic rc48_trim_en_o,
  output logic css_irq_o,
  output logic supply_voltage_monitor_en_o,
  output logic supply_voltage_monitor_irq_o,
  output logic standby_reset_o
);
  logic [2:0] evt_s1;
  logic [2:0] evt_s2;
  logic [2:0] evt_s3;
  logic [7:0] wk_s1;
  logic [7:0] wk_s2;
  logic [7:0] wk_s3;
  logic [7:0] wk_prev;
  logic [2:0] lines_s1;
  logic [2:0] lines_s2;
  logic [2:0] lines_s3;
  logic [lpc_pkg::LPC_EVT_W-1:0] ev_s1;
  logic [lpc_pkg::LPC_EVT_W-1:0] ev_s2;
  logic [lpc_pkg::LPC_EVT_W-1:0] ev_s3;
  logic ev_any;
  logic wk_rise;
  logic rst_pin_low;
  logic standby_exit;
  logic ext_fail;
  logic ext_lock;
  logic svm_below;
  lpc_pkg::lpc_mode_t next_mode;
  lpc_pkg::lpc_reg_ctl_t next_reg;
  lpc_pkg::lpc_clk_ctl_t next_clk;
  logic [2:0] next_grant;
  logic [7:0] ahb_mhz;
  logic [7:0] apb_mhz;

  // Three-stage capture of pin-side inputs; second and third must agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
      wk_s1 <= 8'h0;
      wk_s2 <= 8'h0;
      wk_s3 <= 8'h0;
      lines_s1 <= 3'h4;
      lines_s2 <= 3'h4;
      lines_s3 <= 3'h4;
    end else begin
      ev_s1 <= external_event_lines_i;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
      wk_s1 <= wakeup_pins_i;
      wk_s2 <= wk_s1;
      wk_s3 <= wk_s2;
      lines_s1 <= {external_reset_pin_n_i, rtc_event_i, supply_voltage_monitor_below_i};
      lines_s2 <= lines_s1;
      lines_s3 <= lines_s2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wk_prev <= 8'h0;
    end else begin
      wk_prev <= wk_s2 & wk_s3;
    end
  end

  assign ev_any = |(ev_s2 & ev_s3);
  assign wk_rise = |((wk_s2 & wk_s3) & ~wk_prev);
  assign rst_pin_low = ~lines_s2[2] & ~lines_s3[2];
  assign standby_exit = rst_pin_low | independent_watchdog_reset_i | wk_rise
    | (lines_s2[1] & lines_s3[1]);
  assign svm_below = lines_s2[0] & lines_s3[0];

  // Mode sequencing; software chooses target, wait instruction enters it
  always_comb begin
    next_mode = mode_o;
    case (mode_o)
      lpc_pkg::LPC_RUN: begin
        if (wait_i && target_mode_i != lpc_pkg::LPC_RUN) begin
          next_mode = target_mode_i;
        end
      end
      lpc_pkg::LPC_SLEEP: begin
        if (irq_event_i || ev_any) begin
          next_mode = lpc_pkg::LPC_RUN;
        end
      end
      lpc_pkg::LPC_STOP: begin
        if (ev_any) begin
          next_mode = lpc_pkg::LPC_RUN;
        end
      end
      lpc_pkg::LPC_STANDBY: begin
        if (standby_exit) begin
          next_mode = lpc_pkg::LPC_RUN;
        end
      end
      default: next_mode = lpc_pkg::LPC_RUN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o <= lpc_pkg::LPC_RUN;
    end else begin
      mode_o <= next_mode;
    end
  end

  // Standby loses core state, so leaving it is a full reset of the core
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_reset_o <= 1'b0;
    end else begin
      standby_reset_o <= (mode_o == lpc_pkg::LPC_STANDBY) && standby_exit;
    end
  end

  // Regulator and clock enables per mode
  always_comb begin
    next_reg = lpc_pkg::LPC_RST_REG;
    next_clk = lpc_pkg::LPC_RST_CLK;
    next_grant = 3'h0;
    next_clk.rc8_en = 1'b1;
    next_clk.ext_osc_en = (clk_src_sel_i == lpc_pkg::LPC_SRC_EXT);
    next_clk.pll_en = (clk_src_sel_i == lpc_pkg::LPC_SRC_PLL);
    next_clk.rc48_en = (clk_src_sel_i == lpc_pkg::LPC_SRC_RC48) || pll_from_rc48_o;
    case (next_mode)
      lpc_pkg::LPC_RUN: begin
        next_reg.reg_lowpower = 1'b0;
      end
      lpc_pkg::LPC_SLEEP: begin
        next_clk.cpu_clk_en = 1'b0;
      end
      lpc_pkg::LPC_STOP: begin
        next_clk = '0;
        next_reg.reg_lowpower = low_power_regulator_sel_i;
        if (|rc_request_i) begin
          next_reg.reg_lowpower = 1'b0;
          next_clk.rc8_en = !reg_ctl_o.reg_lowpower;
          next_grant = reg_ctl_o.reg_lowpower ? 3'h0 : rc_request_i;
        end
      end
      lpc_pkg::LPC_STANDBY: begin
        next_clk = '0;
        next_reg.reg_on = 1'b0;
        next_reg.reg_lowpower = 1'b0;
        next_reg.reg_hiz = 1'b1;
        next_reg.core_power = 1'b0;
      end
      default: begin
        next_reg = lpc_pkg::LPC_RST_REG;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_ctl_o <= lpc_pkg::LPC_RST_REG;
      clk_ctl_o <= lpc_pkg::LPC_RST_CLK;
      rc_grant_o <= 3'h0;
      rtc_wdg_clk_en_o <= 1'b1;
    end else begin
      reg_ctl_o <= next_reg;
      clk_ctl_o <= next_clk;
      rc_grant_o <= next_grant;
      rtc_wdg_clk_en_o <= 1'b1;
    end
  end

  lpc_clk_mon #(
    .WIN_CYC(MON_CYC)
  ) u_mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .enable_i(clk_src_o == lpc_pkg::LPC_SRC_EXT && mode_o == lpc_pkg::LPC_RUN),
    .ext_clk_i(ext_clk_i),
    .fail_o(ext_fail)
  );

  // Source selection, failure fallback; a new bus divider is refused if it would put its clock above the limit
  assign ahb_mhz = src_mhz_i >> ahb_div_i;
  assign apb_mhz = ahb_mhz >> apb_div_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_src_o <= lpc_pkg::lpc_src_t'(lpc_pkg::LPC_RST_SRC);
      pll_from_rc48_o <= 1'b0;
      ahb_div_o <= lpc_pkg::LPC_RST_DIV;
      apb_div_o <= lpc_pkg::LPC_RST_DIV;
      rc48_trim_en_o <= 1'b0;
    end else begin
      if (ext_fail) begin
        clk_src_o <= lpc_pkg::LPC_SRC_RC8;
      end else if (mode_o == lpc_pkg::LPC_RUN && !ext_lock) begin
        clk_src_o <= clk_src_sel_i;
      end
      pll_from_rc48_o <= (clk_src_sel_i == lpc_pkg::LPC_SRC_PLL)
        && clock_recovery_unit_en_i;
      rc48_trim_en_o <= clock_recovery_unit_en_i
        && (clk_src_sel_i == lpc_pkg::LPC_SRC_RC48 || pll_from_rc48_o);
      if (ahb_mhz <= 8'(lpc_pkg::LPC_BUS_MAX_MHZ)) begin
        ahb_div_o <= ahb_div_i;
      end
      if (apb_mhz <= 8'(lpc_pkg::LPC_BUS_MAX_MHZ)) begin
        apb_div_o <= apb_div_i;
      end
    end
  end

  // Fallback sticks until software moves the selection off the external clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_lock <= 1'b0;
    end else if (ext_fail) begin
      ext_lock <= 1'b1;
    end else if (clk_src_sel_i != lpc_pkg::LPC_SRC_EXT) begin
      ext_lock <= 1'b0;
    end
  end

  // Failure flag and supply monitor interrupt; both registered from their sources every cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      css_irq_o <= 1'b0;
      supply_voltage_monitor_en_o <= 1'b0;
      supply_voltage_monitor_irq_o <= 1'b0;
    end else begin
      css_irq_o <= ext_fail && css_irq_en_i;
      supply_voltage_monitor_en_o <= supply_voltage_monitor_en_i;
      supply_voltage_monitor_irq_o <= supply_voltage_monitor_en_i && svm_below;
    end
  end

  a_sleep_cpu_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_SLEEP |-> !clk_ctl_o.cpu_clk_en)
    else $error("cpu clock runs in sleep");
  a_run_main_reg: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o != lpc_pkg::LPC_STOP |-> !reg_ctl_o.reg_lowpower)
    else $error("low-power regulator outside stop");
  a_stop_clocks_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_STOP |-> !clk_ctl_o.pll_en && !clk_ctl_o.core_clk_en)
    else $error("clocks running in stop");
  a_standby_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_STANDBY |-> !reg_ctl_o.reg_on && reg_ctl_o.reg_hiz)
    else $error("regulator on in standby");
  a_rc_grant_main: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    |rc_grant_o |-> !reg_ctl_o.reg_lowpower && $past(!reg_ctl_o.reg_lowpower))
    else $error("rc clock granted on low-power regulator");
  a_stop_wake: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_STOP && ev_any |=> mode_o == lpc_pkg::LPC_RUN)
    else $error("stop not left on event");
  a_fail_fallback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_fail |=> clk_src_o == lpc_pkg::LPC_SRC_RC8 && css_irq_o == $past(css_irq_en_i))
    else $error("no fallback on clock failure");
  a_fallback_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ext_lock |-> clk_src_o == lpc_pkg::LPC_SRC_RC8)
    else $error("external clock reselected after failure");
  a_keep_rtc_clk: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rtc_wdg_clk_en_o)
    else $error("rtc clock stopped");
  a_svm_gated: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    supply_voltage_monitor_irq_o |-> $past(supply_voltage_monitor_en_i))
    else $error("monitor interrupt while disabled");
  c_enter_stop: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_RUN ##1 mode_o == lpc_pkg::LPC_STOP);
  c_standby_exit: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_o == lpc_pkg::LPC_STANDBY ##1 standby_reset_o);
  c_rc_grant: cover property (@(posedge clk_i) disable iff (!rst_n_i) |rc_grant_o);
endmodule
`default_nettype wire

// file: verilog/lpc_pkg.sv
/*
  Package for the low-power mode and clock control block: types, codes,
  reset values and cycle counts shared by the controller and its monitor.
  Assumes a 250 MHz system clock and no register bus.
*/
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_RUN,
    LPC_SLEEP,
    LPC_STOP,
    LPC_STANDBY
  } lpc_mode_t;

  typedef enum logic [1:0] {
    LPC_SRC_RC8,
    LPC_SRC_EXT,
    LPC_SRC_PLL,
    LPC_SRC_RC48
  } lpc_src_t;

  typedef struct packed {
    logic reg_on;
    logic reg_lowpower;
    logic reg_hiz;
    logic core_power;
  } lpc_reg_ctl_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic rc8_en;
    logic ext_osc_en;
    logic rc48_en;
  } lpc_clk_ctl_t;

  localparam int unsigned LPC_EVT_W = 22;
  localparam int unsigned LPC_CLK_MHZ = 250;
  localparam int unsigned LPC_BUS_MAX_MHZ = 48;
  localparam int unsigned LPC_RC8_MHZ = 8;
  localparam int unsigned LPC_RC48_MHZ = 48;
  localparam int unsigned LPC_EXT_MAX_MHZ = 32;
  localparam int unsigned LPC_EXT_MIN_MHZ = 4;
  localparam int unsigned LPC_PLL_MAX_MHZ = 48;
  // Window in ns, converted to cycles; external clock needs at least two rising edges per window
  localparam int unsigned LPC_MON_NS = 1000;
  localparam int unsigned LPC_MON_CYC = LPC_MON_NS * LPC_CLK_MHZ / 1000;
  localparam int unsigned LPC_MON_MIN_EDGES = 2;
  localparam logic [1:0] LPC_RST_SRC = 2'h0;
  localparam logic [2:0] LPC_RST_DIV = 3'h0;
  localparam lpc_reg_ctl_t LPC_RST_REG = 4'h9;
  localparam lpc_clk_ctl_t LPC_RST_CLK = 6'h34;
endpackage

// file: verilog/lpc_clk_mon.sv
/*
  External clock failure monitor: counts synchronised edges of the
  external oscillator in fixed windows of the system clock.
  Assumes the external clock is far slower than the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_clk_mon #(
  parameter int unsigned WIN_CYC = lpc_pkg::LPC_MON_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  input wire logic ext_clk_i,
  output logic fail_o
);
  logic [2:0] sync;
  logic [15:0] win_cnt;
  logic [3:0] edges;
  logic edge_seen;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], ext_clk_i};
    end
  end

  assign edge_seen = sync[1] & ~sync[2];

  // Window of edges; too few edges means the oscillator stopped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_cnt <= 16'h0;
      edges <= 4'h0;
      fail_o <= 1'b0;
    end else if (!enable_i) begin
      win_cnt <= 16'h0;
      edges <= 4'h0;
      fail_o <= 1'b0;
    end else if (win_cnt == 16'(WIN_CYC - 1)) begin
      win_cnt <= 16'h0;
      edges <= 4'h0;
      fail_o <= (edges < 4'(lpc_pkg::LPC_MON_MIN_EDGES));
    end else begin
      win_cnt <= win_cnt + 16'h1;
      if (edge_seen && edges != 4'hf) begin
        edges <= edges + 4'h1;
      end
      fail_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: tb/lpc_core_model.sv
/*
  Processor core model: picks the target mode, then issues the wait
  instruction one cycle later. Assumes bench requests on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_core_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enter_i,
  input wire lpc_pkg::lpc_mode_t mode_i,
  output lpc_pkg::lpc_mode_t target_mode_o,
  output logic wait_o
);
  logic pend;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_mode_o <= lpc_pkg::LPC_RUN;
      wait_o <= 1'b0;
      pend <= 1'b0;
    end else begin
      pend <= enter_i;
      wait_o <= pend;
      if (enter_i) begin
        target_mode_o <= mode_i;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/lpc_ctrl_test.sv
/*
  Self-checking bench for the power mode and clock controller.
  Assumes the core model drives mode requests; the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module lpc_ctrl_test;
  typedef struct packed {
    lpc_pkg::lpc_mode_t m;
    logic lp;
    logic [3:0] rg;
    logic [4:0] ck;
    logic [2:0] wk;
  } lpc_row_t;
  localparam int unsigned MON = 50;
  lpc_row_t rows [8];
  logic clk_i, rst_n_i, enter, lp_sel, irq_ev, rtc_ev, wdg_rst, rst_pin_n, ext_clk, ext_run;
  logic css_en, cru_en, svm_en, svm_below, wait_w, rtc_clk, trim, css_irq, svm_en_o, svm_irq;
  logic sb_rst, pll48, css_seen, sb_seen;
  lpc_pkg::lpc_mode_t req_mode, target_mode, mode_o;
  logic [lpc_pkg::LPC_EVT_W-1:0] ev_lines;
  logic [7:0] wk_pins, src_mhz;
  logic [2:0] rc_req, ahb_div, apb_div, ahb_o, apb_o, rc_grant;
  lpc_pkg::lpc_src_t src_sel, src_o;
  lpc_pkg::lpc_reg_ctl_t reg_ctl;
  lpc_pkg::lpc_clk_ctl_t clk_ctl;
  int failures, comparisons, cycles;

  lpc_core_model u_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .enter_i(enter), .mode_i(req_mode),
    .target_mode_o(target_mode), .wait_o(wait_w));
  lpc_ctrl #(.MON_CYC(MON)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .target_mode_i(target_mode),
    .low_power_regulator_sel_i(lp_sel), .wait_i(wait_w), .irq_event_i(irq_ev),
    .external_event_lines_i(ev_lines), .wakeup_pins_i(wk_pins), .rtc_event_i(rtc_ev),
    .independent_watchdog_reset_i(wdg_rst), .external_reset_pin_n_i(rst_pin_n),
    .rc_request_i(rc_req), .clk_src_sel_i(src_sel), .ahb_div_i(ahb_div), .apb_div_i(apb_div),
    .src_mhz_i(src_mhz), .ext_clk_i(ext_clk), .css_irq_en_i(css_en),
    .clock_recovery_unit_en_i(cru_en), .supply_voltage_monitor_en_i(svm_en),
    .supply_voltage_monitor_below_i(svm_below), .mode_o(mode_o), .reg_ctl_o(reg_ctl),
    .clk_ctl_o(clk_ctl), .clk_src_o(src_o), .pll_from_rc48_o(pll48), .ahb_div_o(ahb_o),
    .apb_div_o(apb_o), .rc_grant_o(rc_grant), .rtc_wdg_clk_en_o(rtc_clk),
    .rc48_trim_en_o(trim), .css_irq_o(css_irq), .supply_voltage_monitor_en_o(svm_en_o),
    .supply_voltage_monitor_irq_o(svm_irq), .standby_reset_o(sb_rst));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always #20 if (ext_run) ext_clk = ~ext_clk;

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (css_irq === 1'b1) css_seen <= 1'b1;
    if (sb_rst === 1'b1) sb_seen <= 1'b1;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic enter_mode(input lpc_pkg::lpc_mode_t m, input logic lp);
    lp_sel = lp;
    req_mode = m;
    enter = 1'b1;
    tick(1);
    enter = 1'b0;
    tick(4);
  endtask
  task automatic wake(input logic [2:0] k);
    int n;
    case (k)
      3'h0: irq_ev = 1'b1;
      3'h1: ev_lines[0] = 1'b1;
      3'h2: ev_lines[21] = 1'b1;
      3'h3: wk_pins[7] = 1'b1;
      3'h4: rtc_ev = 1'b1;
      3'h5: wdg_rst = 1'b1;
      default: rst_pin_n = 1'b0;
    endcase
    tick(2);
    {irq_ev, rtc_ev, wdg_rst, rst_pin_n, ev_lines, wk_pins} = {4'h1, 30'h0};
    n = 0;
    while (mode_o !== lpc_pkg::LPC_RUN && n < 20) begin
      tick(1);
      n++;
    end
    tick(1);
  endtask

  initial begin
    {rst_n_i, enter, lp_sel, irq_ev, rtc_ev, wdg_rst, ext_clk, ext_run} = 8'h0;
    {css_en, cru_en, svm_en, svm_below, css_seen, sb_seen} = 6'h0;
    rst_pin_n = 1'b1;
    {ev_lines, wk_pins, rc_req, ahb_div, apb_div} = 39'h0;
    src_mhz = 8'h08;
    req_mode = lpc_pkg::LPC_RUN;
    src_sel = lpc_pkg::LPC_SRC_RC8;
    {failures, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    rows = '{'{lpc_pkg::LPC_SLEEP, 1'b0, 4'h9, 5'h0a, 3'h0}, '{lpc_pkg::LPC_SLEEP, 1'b1, 4'h9, 5'h0a, 3'h1},
      '{lpc_pkg::LPC_STOP, 1'b0, 4'h9, 5'h00, 3'h1}, '{lpc_pkg::LPC_STOP, 1'b1, 4'hd, 5'h00, 3'h2},
      '{lpc_pkg::LPC_STANDBY, 1'b0, 4'h2, 5'h00, 3'h3}, '{lpc_pkg::LPC_STANDBY, 1'b0, 4'h2, 5'h00, 3'h4},
      '{lpc_pkg::LPC_STANDBY, 1'b0, 4'h2, 5'h00, 3'h5}, '{lpc_pkg::LPC_STANDBY, 1'b0, 4'h2, 5'h00, 3'h6}};
    tick(2);
    rst_n_i = 1'b1;
    tick(1);
    check("mode", mode_o, 8'h0);
    check("reg", reg_ctl, 8'h09);
    check("clk", clk_ctl, 8'h34);
    check("src", src_o, 8'h0);
    foreach (rows[i]) begin
      sb_seen = 1'b0;
      enter_mode(rows[i].m, rows[i].lp);
      check("mode", mode_o, rows[i].m);
      check("reg", reg_ctl, rows[i].rg);
      check("clk", clk_ctl[5:1], rows[i].ck);
      check("rtc_clk", rtc_clk, 8'h1);
      wake(rows[i].wk);
      check("woken", mode_o, 8'h0);
      check("reg_run", reg_ctl, 8'h09);
      check("clk_run", clk_ctl[5:1], 8'h1a);
      if (rows[i].m == lpc_pkg::LPC_STANDBY) check("sb_rst", sb_seen, 8'h1);
    end
    enter_mode(lpc_pkg::LPC_STOP, 1'b1);
    rc_req = 3'h2;
    tick(4);
    check("lp_reg", reg_ctl.reg_lowpower, 8'h0);
    check("grant", rc_grant, 8'h2);
    check("rc8", clk_ctl.rc8_en, 8'h1);
    rc_req = 3'h0;
    wake(3'h1);
    src_mhz = 8'd96;
    ahb_div = 3'h1;
    apb_div = 3'h2;
    tick(4);
    check("ahb", ahb_o, 8'h1);
    check("apb", apb_o, 8'h2);
    ahb_div = 3'h0;
    apb_div = 3'h0;
    tick(4);
    check("ahb_refused", ahb_o, 8'h1);
    check("apb_refused", apb_o, 8'h2);
    src_sel = lpc_pkg::LPC_SRC_RC48;
    cru_en = 1'b1;
    tick(4);
    check("src48", src_o, 8'h3);
    check("trim48", trim, 8'h1);
    check("rc48_on", clk_ctl.rc48_en, 8'h1);
    src_sel = lpc_pkg::LPC_SRC_PLL;
    tick(4);
    check("src_pll", src_o, 8'h2);
    check("pll48", pll48, 8'h1);
    check("trim_pll", trim, 8'h1);
    css_en = 1'b1;
    ext_run = 1'b1;
    src_sel = lpc_pkg::LPC_SRC_EXT;
    tick(2 * MON + 5);
    check("src_ext", src_o, 8'h1);
    check("css_quiet", css_seen, 8'h0);
    ext_run = 1'b0;
    tick(3 * MON);
    check("src_fallback", src_o, 8'h0);
    check("css_irq", css_seen, 8'h1);
    src_sel = lpc_pkg::LPC_SRC_RC8;
    svm_below = 1'b1;
    tick(6);
    check("svm_off", svm_irq, 8'h0);
    svm_en = 1'b1;
    tick(6);
    check("svm_irq", svm_irq, 8'h1);
    check("svm_en", svm_en_o, 8'h1);
    enter_mode(lpc_pkg::LPC_STOP, 1'b1);
    rst_n_i = 1'b0;
    tick(1);
    check("rst_mode", mode_o, 8'h0);
    check("rst_reg", reg_ctl, 8'h09);
    rst_n_i = 1'b1;
    tick(1);
    check("rst_src", src_o, 8'h0);
    check("rst_svm", svm_irq, 8'h0);
    tick(4);
    check("svm_again", svm_irq, 8'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
